//--- testbench/bnl_nvm_model.sv
module bnl_nvm_model
    import bnl_pkg::*;
(
    // clock
    input  wire logic              core_clk,
    // read port
    input  wire logic              nvm_rd_en,
    input  wire logic [NVM_AW-1:0] nvm_addr,
    output logic      [7:0]        nvm_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // whole array; header, factory bytes, user load and overlay filled by the bench
    logic [7:0] mem [NVM_SIZE];
    logic [7:0] idle_q = 8'h5a;
    // data stands while the read is asked for; the design takes it at the edge ending it
    assign nvm_rd_data = nvm_rd_en ? mem[nvm_addr] : idle_q;
    // a released line shows the inverse of its last value so stale data never passes
    always @(posedge core_clk) begin
        idle_q <= ~nvm_rd_data;
    end
endmodule

//--- testbench/test_bnl_boot_loader.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_bnl_boot_loader;
    import bnl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FIX = 200;
    localparam int BC  = 4; // cycles per user byte with KB_CYC 4096
    logic              core_clk   = 1'b0;
    logic              rst_n      = 1'b0;
    logic              retest_pin = 1'b0;
    logic [3:0]        reg_addr   = 4'h0;
    logic [7:0]        reg_wdata  = 8'h00;
    logic              reg_we     = 1'b0;
    logic              reg_re     = 1'b0;
    logic              nvm_rd_en, ram_we, cpu_halt, cpu_start, sys_init_n, clk_sel;
    logic              dbg_en, prog_ok, rom_blk, cpu_blk, gpio_od, rd_d;
    logic [NVM_AW-1:0] nvm_addr;
    logic [RAM_AW-1:0] ram_addr;
    logic [7:0]        nvm_rd_data, ram_wdata, gpio_latch, reg_rdata, re_exp, r;
    logic [15:0]       cpu_pc;
    logic [20:0]       we_exp;
    logic [7:0]        rq[$];
    logic [20:0]       wq[$];
    int                mismatches = 0, n_checks = 0, cyc = 0, start_cyc = 0, n_start = 0;
    int                last_we = 0;
    bnl_boot_loader #(.FIXED_CYC(FIX), .KB_CYC(4096)) i_dut (.core_clk(core_clk),
        .rst_n(rst_n), .nvm_rd_en(nvm_rd_en), .nvm_addr(nvm_addr), .nvm_rd_data(nvm_rd_data),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .cpu_halt(cpu_halt),
        .cpu_start(cpu_start), .cpu_pc(cpu_pc), .sys_init_n(sys_init_n),
        .clk_sel_internal(clk_sel), .retest_pin(retest_pin), .debug_port_en(dbg_en),
        .nvm_prog_allow(prog_ok), .rom_read_block(rom_blk), .nvm_cpu_block(cpu_blk),
        .gpio_latch(gpio_latch), .gpio_open_drain(gpio_od), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
    bnl_nvm_model i_nvm (.core_clk(core_clk), .nvm_rd_en(nvm_rd_en), .nvm_addr(nvm_addr),
        .nvm_rd_data(nvm_rd_data));
    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // output watcher: oldest note off each queue when a result appears
    always @(posedge core_clk) begin
        cyc <= rst_n ? cyc + 1 : 0;
        rd_d <= reg_re;
        if (rd_d) begin
            re_exp = rq.pop_front();
            `CHK("reg_rdata", re_exp, reg_rdata)
        end
        if (ram_we) begin
            last_we <= cyc;
            if (wq.size() == 0) wq.push_back(21'bx);
            we_exp = wq.pop_front();
            `CHK("ram write", we_exp, {ram_addr, ram_wdata})
        end
        if (cpu_start) begin
            start_cyc <= cyc;
            n_start <= n_start + 1;
        end
    end
    // register bus cycles, one strobe cycle each
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        `CHK("reset state", {2'b10, 16'h0, 1'b1}, {cpu_halt, sys_init_n, cpu_pc, clk_sel})
        `CHK("port reset", {8'hff, 1'b1}, {gpio_latch, gpio_od})
        `CHK("strobes in reset", 3'b000, {nvm_rd_en, ram_we, cpu_start})
        @(posedge core_clk);
        rst_n <= 1'b1;
    endtask
    // one boot from a fresh header; bytes past the user end stand for the overlay
    task automatic boot(input logic [2:0] lvl, input logic uc, input logic ovr, input logic por);
        int n, fd, ue, k;
        logic ok, usr, run, dbg, pa;
        n = 4 + $urandom_range(12);
        fd = 12'h400 + $urandom_range(255);
        ue = 16 + n;
        ok = lvl == LVL_FACTORY || lvl == LVL_USER || lvl == LVL_RUN;
        usr = ok && lvl != LVL_FACTORY && !ovr;
        run = usr && (lvl == LVL_RUN || uc);
        dbg = lvl != LVL_RUN || ovr;
        pa = ok && lvl != LVL_RUN;
        i_nvm.mem[0] = {5'h0, lvl};
        i_nvm.mem[1] = {7'h0, uc};
        i_nvm.mem[2] = 8'h00;
        i_nvm.mem[3] = 8'd16;
        i_nvm.mem[4] = 8'(ue >> 8);
        i_nvm.mem[5] = 8'(ue);
        i_nvm.mem[6] = 8'(fd >> 8);
        i_nvm.mem[7] = 8'(fd);
        for (k = 8; k < ue + 8; k++) i_nvm.mem[k] = 8'($urandom);
        for (k = 0; k < 8; k++) wq.push_back({13'(fd + k), i_nvm.mem[8 + k]});
        if (usr) for (k = 0; k < n; k++) wq.push_back({13'(k), i_nvm.mem[16 + k]});
        n_start = 0;
        do_reset();
        if (ovr) wr(REG_FLAGS, 8'h04);
        repeat (FIX + BC * n + 40) @(posedge core_clk);
        #1;
        `CHK("ram writes left", 0, wq.size())
        `CHK("started", run, n_start == 1)
        if (run) `CHK("boot time", 1'b1, start_cyc >= FIX - 8 + BC * n && start_cyc <= FIX + BC * n + 20)
        if (!usr) `CHK("short boot", 1'b1, last_we < FIX - 1)
        `CHK("ctl pins", {!run, dbg, pa, 2'b11}, {cpu_halt, dbg_en, prog_ok, rom_blk, cpu_blk})
        rd(REG_PROT, {3'h0, uc, pa, lvl});
        rd(REG_FLAGS, {ok, 1'b1, 3'h0, ovr, 2'b00});
        if (usr) begin
            rd(REG_CPA_HI, 8'he0 | 8'(ue >> 8));
            rd(REG_CPA_LO, 8'(ue));
        end
        if (!dbg) begin
            retest_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            #1;
            `CHK("retest debug", 1'b1, dbg_en)
            @(posedge core_clk);
            retest_pin <= 1'b0;
        end
        if (!run) begin
            wr(REG_FLAGS, por ? 8'h01 : 8'h02);
            repeat (4) @(posedge core_clk);
            #1;
            `CHK("run after flag", {1'b1, 17'h0}, {n_start == 1, cpu_halt, cpu_pc})
        end
        repeat (3) @(posedge core_clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // hang guard, well beyond the expected run length
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    // main sequence: every level, both code-run bits, override and user continue
    initial begin
        void'($urandom(32'h63ce));
        boot(LVL_RUN, 1'b0, 1'b0, 1'b0);
        rd(REG_PORT, 8'hff);
        rd(REG_PMODE, 8'h01);
        r = 8'($urandom);
        wr(REG_PORT, r);
        wr(REG_PMODE, 8'h00);
        wr(REG_PROT, 8'hff);
        rd(REG_PORT, r);
        rd(REG_PROT, {5'h0, LVL_RUN});
        rd(4'hf, 8'h00);
        #1;
        `CHK("port pins", {r, 1'b0}, {gpio_latch, gpio_od})
        @(posedge core_clk);
        boot(LVL_FACTORY, 1'b0, 1'b0, 1'b1);
        boot(LVL_USER, 1'b0, 1'b0, 1'b0);
        boot(LVL_USER, 1'b1, 1'b0, 1'b0);
        boot(LVL_RUN, 1'b1, 1'b1, 1'b1);
        boot(3'h5, 1'b0, 1'b0, 1'b0);
        wrap_up();
    end
endmodule

//--- verilog/bnl_boot_loader.sv
// Notes on behaviour
// [RULE1] copy factory then user load, then run
// [RULE2] boot takes fixed time plus per-kilobyte pacing
// [RULE3] factory-only boot ends under fixed time
// [RULE4] power-on reset is the only reset
// [RULE5] reset halts cpu, loads register defaults
// [RULE6] reset sets port latches ff, open-drain
// [RULE7] reset exit: pc cleared, internal oscillator, boot
// [RULE8] read program level first, act on it
// [RULE9] level readable as three-bit protection field
// [RULE10] factory level blocks rom reads, allows debug
// [RULE11] user level loads but does not start
// [RULE12] run level: no programming, debug only retest
// [RULE13] run level jumps to ram zero
// [RULE14] nvm lives at 0xe000..0xffff, no direct access
// [RULE15] last 64 nvm bytes never loaded
// [RULE16] overlay region untouched at boot
// [RULE17] unified 4.5KB ram receives every copy
// [RULE18] factory level waits for a code-run bit
// [RULE19] override skips user load, enables debug, waits
// [RULE20] user continue enables debug, jumps at once
// [RULE21] region bounds come from factory header
module bnl_boot_loader
    import bnl_pkg::*;
#(
    parameter int FIXED_CYC = BOOT_FIXED_CYC,
    parameter int KB_CYC    = USER_KB_CYC
) (
    // clock and power-on reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // nvm read port, data valid during the enable cycle
    output logic                   nvm_rd_en,
    output logic      [NVM_AW-1:0] nvm_addr,
    input  wire logic [7:0]        nvm_rd_data,
    // ram write port
    output logic                   ram_we,
    output logic      [RAM_AW-1:0] ram_addr,
    output logic      [7:0]        ram_wdata,
    // cpu and system control
    output logic                   cpu_halt,
    output logic                   cpu_start,
    output logic      [15:0]       cpu_pc,
    output logic                   sys_init_n,
    output logic                   clk_sel_internal,
    // protection and debug
    input  wire logic              retest_pin,
    output logic                   debug_port_en,
    output logic                   nvm_prog_allow,
    output logic                   rom_read_block,
    output logic                   nvm_cpu_block,
    // port latches
    output logic      [7:0]        gpio_latch,
    output logic                   gpio_open_drain,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [7:0]        reg_rdata
);
    localparam int BYTE_CYC = KB_CYC / KB_BYTES;
    localparam int FW       = $clog2(FIXED_CYC + 1);

    if (FIXED_CYC < 64) begin : g_chk_fix
        $error("bnl_boot_loader: FIXED_CYC too small for the header and factory phase");
    end
    if (BYTE_CYC < 3) begin : g_chk_kb
        $error("bnl_boot_loader: KB_CYC must give at least three cycles per byte");
    end

    bnl_state_t  state;
    bnl_state_t  next_state;
    logic [7:0]  hdr [HDR_LEN];
    logic [2:0]  hdr_idx;
    logic        pend;
    logic [15:0] src;
    logic [15:0] dst;
    logic [FW-1:0] fix_cnt;
    logic        run_por;
    logic        run_sys;
    logic        boot_override;
    logic        boot_done;
    logic        retest_s;
    logic        byte_tick;

    // header decode: bounds live in nvm, not in this logic
    wire [2:0]  level     = hdr[HDR_LEVEL][2:0];                          // RULE9
    wire        user_continue_bit = hdr[HDR_PROT][PROT_UCONT_BIT];
    wire [15:0] user_beg  = {hdr[HDR_UBEG_HI], hdr[HDR_UBEG_LO]};         // RULE21
    wire [15:0] user_end  = {hdr[HDR_UEND_HI], hdr[HDR_UEND_LO]};
    wire        lvl_run   = (level == LVL_RUN);
    wire        lvl_user  = (level == LVL_USER) || lvl_run;
    wire        level_ok  = (level == LVL_FACTORY) || lvl_user;
    // user copy stops at region end, reserved tail or ram end, whichever first
    wire [15:0] user_lim  = (user_end > USER_LIM_MAX) ? USER_LIM_MAX : user_end; // RULE15 RULE16
    wire        in_fact   = (state == ST_FACT);
    wire        in_user   = (state == ST_USER);
    wire [15:0] copy_lim  = in_fact ? user_beg : user_lim;
    wire        copy_end  = (src >= copy_lim) || (dst >= RAM_LIM);         // RULE17
    wire        copy_go   = in_fact || (in_user && byte_tick);             // RULE2
    wire        issue     = (in_fact || in_user) && !pend && copy_go && !copy_end;
    wire        fix_due   = (fix_cnt >= FW'(FIXED_CYC - 2));               // RULE3
    wire        skip_user = (level == LVL_FACTORY) || !level_ok || boot_override; // RULE19
    wire        go_now    = lvl_run || user_continue_bit;                          // RULE13 RULE20
    wire        code_run  = run_por || run_sys;
    wire        wr_flags  = reg_we && (reg_addr == REG_FLAGS);
    wire        wr_port   = reg_we && (reg_addr == REG_PORT);
    wire        wr_pmode  = reg_we && (reg_addr == REG_PMODE);
    wire [15:0] copy_virt = bnl_to_virt(src);                              // RULE14

    bnl_sync2 #(.W(1)) u_retest_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (retest_pin),
        .sync_out (retest_s)
    );

    // paces the user copy at one byte per kilobyte time share
    bnl_tick_div #(.PERIOD(BYTE_CYC)) u_byte_pace (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .en       (in_user),
        .tick     (byte_tick)
    );

    // sequencing: level first, factory load, then user load by level
    always_comb begin
        next_state = state;
        unique case (state)
            ST_HDR:  if (pend && hdr_idx == 3'(HDR_LEN - 1)) next_state = ST_FACT; // RULE8
            ST_FACT: if (!pend && copy_end) next_state = ST_FIX;
            ST_FIX: begin
                if (fix_due) begin
                    next_state = skip_user ? ST_WAIT : ST_USER;            // RULE10
                end
            end
            ST_USER: begin
                if (!pend && copy_end) begin
                    next_state = (go_now && !boot_override) ? ST_RUN : ST_WAIT; // RULE11
                end
            end
            ST_WAIT: if (code_run) next_state = ST_RUN;                    // RULE18
            ST_RUN:  next_state = ST_RUN;
            default: next_state = ST_HDR;
        endcase
    end

    // state, power-on reset is the only way back to the header read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= ST_HDR;                                               // RULE4 RULE7
        end else begin
            state <= next_state;
        end
    end

    // header capture, one read in flight at a time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hdr_idx <= 3'h0;
            for (int i = 0; i < HDR_LEN; i++) begin
                hdr[i] <= 8'h00;
            end
        end else if (state == ST_HDR && pend) begin
            hdr[hdr_idx] <= nvm_rd_data;
            hdr_idx      <= hdr_idx + 3'h1;
        end
    end

    // nvm read and ram write datapath shared by both copies
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend      <= 1'b0;
            nvm_rd_en <= 1'b0;
            nvm_addr  <= '0;
            ram_we    <= 1'b0;
            ram_addr  <= '0;
            ram_wdata <= 8'h00;
            src       <= 16'h0000;
            dst       <= 16'h0000;
        end else begin
            nvm_rd_en <= 1'b0;
            ram_we    <= 1'b0;
            if (state == ST_HDR) begin
                pend      <= !pend;
                nvm_rd_en <= !pend;
                nvm_addr  <= NVM_AW'(hdr_idx);
                if (next_state == ST_FACT) begin
                    src <= 16'(HDR_LEN);
                    dst <= {hdr[HDR_FDST_HI], nvm_rd_data}; // low target byte lands now
                end
            end else if (issue) begin
                pend      <= 1'b1;
                nvm_rd_en <= 1'b1;
                nvm_addr  <= src[NVM_AW-1:0];
            end else if (pend) begin
                pend      <= 1'b0;
                ram_we    <= 1'b1;                                         // RULE1
                ram_addr  <= dst[RAM_AW-1:0];
                ram_wdata <= nvm_rd_data;
                src       <= src + 16'h0001;
                dst       <= dst + 16'h0001;
            end else if (state == ST_FIX && next_state == ST_USER) begin
                src <= user_beg;
                dst <= 16'h0000;
            end
        end
    end

    // fixed-time budget runs from reset release and saturates
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fix_cnt <= '0;
        end else if (!fix_due) begin
            fix_cnt <= fix_cnt + FW'(1);
        end
    end

    // cpu held until the copy is done; start is a one-cycle pulse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cpu_halt         <= 1'b1;                                      // RULE5
            cpu_start        <= 1'b0;
            cpu_pc           <= PC_RST;                                    // RULE7
            sys_init_n       <= 1'b0;
            clk_sel_internal <= 1'b1;
            boot_done        <= 1'b0;
        end else begin
            sys_init_n <= 1'b1;
            cpu_start  <= 1'b0;
            if (next_state == ST_RUN && state != ST_RUN) begin
                cpu_halt  <= 1'b0;                                         // RULE13
                cpu_start <= 1'b1;
                cpu_pc    <= RUN_ADDR;
            end
            if (next_state == ST_WAIT || next_state == ST_RUN) begin
                boot_done <= 1'b1;
            end
        end
    end

    // protection outputs follow the level once boot is done
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            debug_port_en  <= 1'b0;
            nvm_prog_allow <= 1'b0;
        end else begin
            debug_port_en  <= boot_done && (!lvl_run || retest_s || boot_override); // RULE12
            nvm_prog_allow <= boot_done && level_ok && !lvl_run;           // RULE12
        end
    end
    // rom and factory rows stay hidden at every level; the cpu never sees nvm
    assign rom_read_block = 1'b1;                                          // RULE10
    assign nvm_cpu_block  = 1'b1;                                          // RULE14

    // software registers; port latches reset to all ones in open-drain
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gpio_latch      <= PORT_RST;                                   // RULE6
            gpio_open_drain <= PMODE_OD_RST;
            run_por         <= 1'b0;
            run_sys         <= 1'b0;
            boot_override   <= 1'b0;
        end else begin
            if (wr_port) gpio_latch <= reg_wdata;
            if (wr_pmode) gpio_open_drain <= reg_wdata[0];
            if (wr_flags) begin
                run_por       <= run_por | reg_wdata[FLG_RUN_POR];
                run_sys       <= run_sys | reg_wdata[FLG_RUN_SYS];
                boot_override <= reg_wdata[FLG_OVERRIDE];
            end
        end
    end

    // read mux, unmapped reads return zero
    wire [7:0] rd_prot  = {3'h0, user_continue_bit, nvm_prog_allow, level};
    wire [7:0] rd_flags = {level_ok, boot_done, 3'h0, boot_override, run_sys, run_por};
    wire [7:0] rd_mux   = (reg_addr == REG_PROT)   ? rd_prot :
                          (reg_addr == REG_FLAGS)  ? rd_flags :
                          (reg_addr == REG_CPA_HI) ? copy_virt[15:8] :
                          (reg_addr == REG_CPA_LO) ? copy_virt[7:0] :
                          (reg_addr == REG_PORT)   ? gpio_latch :
                          (reg_addr == REG_PMODE)  ? {7'h00, gpio_open_drain} : 8'h00;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_re) begin
            reg_rdata <= rd_mux;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_enter_run;
        (state != ST_RUN) ##1 (state == ST_RUN);
    endsequence
    sequence s_user_write;
        in_user && ram_we;
    endsequence

    property p_run_from_zero;
        s_enter_run |-> (cpu_pc == RUN_ADDR) && !cpu_halt && cpu_start;
    endproperty
    a_run_from_zero: assert property (p_run_from_zero) else $error("bad run entry"); // RULE13
    property p_halt_until_done;
        (state != ST_RUN) |-> cpu_halt;
    endproperty
    a_halt_until_done: assert property (p_halt_until_done) else $error("cpu ran early"); // RULE1
    property p_reset_defaults;
        $rose(rst_n) |-> gpio_latch == PORT_RST && gpio_open_drain && cpu_halt && cpu_pc == PC_RST;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset values"); // RULE6
    property p_run_locked;
        (boot_done && lvl_run && !retest_s && !boot_override) |=> !debug_port_en && !nvm_prog_allow;
    endproperty
    a_run_locked: assert property (p_run_locked) else $error("run part unlocked"); // RULE12
    property p_user_paced;
        s_user_write |=> !ram_we [*2];
    endproperty
    a_user_paced: assert property (p_user_paced) else $error("user copy too fast"); // RULE2
    property p_tail_kept;
        in_user && nvm_rd_en |-> nvm_addr < NVM_AW'(USER_LIM_MAX) && ram_addr < RAM_AW'(RAM_SIZE);
    endproperty
    a_tail_kept: assert property (p_tail_kept) else $error("reserved tail read"); // RULE15
    property p_factory_waits;
        ((state == ST_FIX) && fix_due && skip_user) |=> (state == ST_WAIT) && cpu_halt;
    endproperty
    a_factory_waits: assert property (p_factory_waits) else $error("wait skipped"); // RULE19
    property p_wait_release;
        (state == ST_WAIT && code_run) |=> (state == ST_RUN) ##1 !cpu_start;
    endproperty
    a_wait_release: assert property (p_wait_release) else $error("flag not honoured"); // RULE18
    property p_fix_budget;
        (state == ST_FACT) |-> !fix_due;
    endproperty
    a_fix_budget: assert property (p_fix_budget) else $error("fixed budget exceeded"); // RULE3
endmodule

//--- verilog/bnl_pkg.sv
package bnl_pkg;

    // memory geometry
    localparam int          NVM_SIZE       = 8192;     // 8KB one-time-programmable array
    localparam int          NVM_RSV_BYTES  = 64;       // factory tail, never part of a load
    localparam logic [15:0] NVM_VIRT_BASE  = 16'he000; // virtual window 0xe000..0xffff
    localparam logic [15:0] NVM_VIRT_LAST  = 16'hffff;
    localparam int          RAM_SIZE       = 4608;     // 4.5KB unified code/data ram
    localparam int          NVM_AW         = 13;
    localparam int          RAM_AW         = 13;
    localparam logic [15:0] USER_LIM_MAX   = 16'(NVM_SIZE - NVM_RSV_BYTES);
    localparam logic [15:0] RAM_LIM        = 16'(RAM_SIZE);

    // factory header layout at the start of the factory region
    localparam int          HDR_LEN        = 8;
    localparam int          HDR_LEVEL      = 0;        // program level in [2:0]
    localparam int          HDR_PROT       = 1;        // boot protection byte
    localparam int          HDR_UBEG_HI    = 2;        // user region begin
    localparam int          HDR_UBEG_LO    = 3;
    localparam int          HDR_UEND_HI    = 4;        // user region end, exclusive
    localparam int          HDR_UEND_LO    = 5;
    localparam int          HDR_FDST_HI    = 6;        // ram target of factory data
    localparam int          HDR_FDST_LO    = 7;
    localparam int          PROT_UCONT_BIT = 0;        // user continue, one-way bit

    // program level codes
    localparam logic [2:0]  LVL_FACTORY    = 3'h0;
    localparam logic [2:0]  LVL_USER       = 3'h1;
    localparam logic [2:0]  LVL_RUN        = 3'h3;

    // timing
    localparam real         CLK_MHZ        = 200.0;
    localparam real         BOOT_FIXED_MS  = 2.0;
    localparam real         USER_KB_MS     = 3.6;
    localparam int          KB_BYTES       = 1024;
    localparam int          BOOT_FIXED_CYC = int'($floor(BOOT_FIXED_MS * 1000.0 * CLK_MHZ));
    localparam int          USER_KB_CYC    = int'($floor(USER_KB_MS * 1000.0 * CLK_MHZ + 0.5));

    // register map
    localparam logic [3:0]  REG_PROT       = 4'h0;
    localparam logic [3:0]  REG_FLAGS      = 4'h1;
    localparam logic [3:0]  REG_CPA_HI     = 4'h2;
    localparam logic [3:0]  REG_CPA_LO     = 4'h3;
    localparam logic [3:0]  REG_PORT       = 4'h4;
    localparam logic [3:0]  REG_PMODE      = 4'h5;
    localparam int          FLG_RUN_POR    = 0;
    localparam int          FLG_RUN_SYS    = 1;
    localparam int          FLG_OVERRIDE   = 2;
    localparam int          FLG_DONE       = 6;
    localparam int          FLG_OK         = 7;
    localparam logic [7:0]  PORT_RST       = 8'hff;
    localparam logic        PMODE_OD_RST   = 1'b1;
    localparam logic [15:0] PC_RST         = 16'h0000;
    localparam logic [15:0] RUN_ADDR       = 16'h0000;

    typedef enum logic [2:0] {
        ST_HDR  = 3'b000,
        ST_FACT = 3'b001,
        ST_FIX  = 3'b010,
        ST_USER = 3'b011,
        ST_WAIT = 3'b100,
        ST_RUN  = 3'b101
    } bnl_state_t;

    // nvm offset to its address in the virtual window
    function automatic logic [15:0] bnl_to_virt(input logic [15:0] off);
        return NVM_VIRT_BASE | (off & 16'h1fff);
    endfunction

endpackage

//--- verilog/bnl_sync2.sv
module bnl_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

//--- verilog/bnl_tick_div.sv
module bnl_tick_div #(
    parameter int PERIOD = 703
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // run control and pulse out
    input  wire logic en,
    output logic      tick
);
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

    logic [CW-1:0] cnt;
    wire           wrap = (cnt == CW'(PERIOD - 1));

    if (PERIOD < 2) begin : g_chk
        $error("bnl_tick_div: PERIOD must be at least 2");
    end

    // counter restarts whenever disabled, so the first pulse is a full period out
    always_ff @(posedge core_clk) begin
        if (!rst_n || !en) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= wrap ? '0 : cnt + CW'(1);
            tick <= wrap;
        end
    end
endmodule
